// >>> sim/host_model.sv
// Host side model: answers node send requests and decodes node bytes
module host_model #(
   parameter int BIT_P = 347  // Bit period in clock cycles
) (
   input  wire logic        clock_i,     // Bench clock
   input  wire logic        serial_i,    // Node serial data
   input  wire logic        request_n_i, // Node send request, low active
   input  wire logic [15:0] delay_i,     // Answer delay in cycles
   input  wire logic        drop_i,      // Drop clear on a start bit
   output logic             clear_n_o,   // Host receive clear, low active
   output logic [7:0]       byte_o,      // Decoded byte
   output logic             strobe_o     // Pulse: byte_o new
);
   timeunit 1ns;
   timeprecision 1ps;
   int         wait_c = 0;
   int         cnt    = 0;
   int         bitn   = -1;
   logic [9:0] sh     = '0;
   initial begin
      clear_n_o = 1'b1;
      strobe_o  = 1'b0;
      byte_o    = 8'h00;
   end
   // Clear follows the request after the delay; decoder samples mid-bit
   always @(negedge clock_i) begin
      strobe_o <= 1'b0;
      if (clear_n_o === request_n_i) wait_c = 0;
      else if (wait_c >= delay_i) clear_n_o <= request_n_i;
      else wait_c++;
      if (bitn < 0) begin
         if (serial_i === 1'b0) begin
            bitn = 0;
            cnt  = 0;
            if (drop_i) clear_n_o <= 1'b1;
         end
      end else begin
         cnt++;
         if (cnt == BIT_P / 2 + bitn * BIT_P) begin
            sh = {serial_i, sh[9:1]};
            bitn++;
         end
         if (bitn == 10) begin
            byte_o   <= sh[8:1];
            strobe_o <= sh[9];
            bitn = -1;
         end
      end
   end
endmodule : host_model

// >>> sim/node_host_link_tb.sv
// Self-checking bench for the node host link
module node_host_link_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = 200;
   localparam int BIT = 347;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        req_n = 1'b1, ts_n = 1'b1, doze_n = 1'b1, radio = 1'b0;
   logic        srx = 1'b1, gap = 1'b0, valid = 1'b0, drop = 1'b0;
   logic [15:0] dly = 16'h0028;
   logic        clr_n, take, rxv, stx, nrc_n, nsr_n, doze, roff, hstb;
   logic [7:0]  rxd, hbyte;
   logic [7:0]  rq[$], tq[$];
   logic [31:0] got_word = '0, seed = 32'h68DE, tus;
   int          err_count = 0, checks = 0, cyc = 0, nstb = 0, n;
   node_link_pkg::link_byte_t txb = '0;
   wire  [6:0]  obs = {clr_n, stx, take, nsr_n, nrc_n, doze, roff};

   node_host_link #(.GAP_CYCLES_P(GAP)) uut (
      .clock_i(clock_i), .reset_i(reset_i), .host_i({req_n, clr_n, ts_n, doze_n, radio}),
      .serial_rx_i(srx), .gap_mode_i(gap), .tx_byte_i(txb), .tx_valid_i(valid),
      .tx_take_o(take), .rx_data_o(rxd), .rx_valid_o(rxv), .serial_tx_o(stx),
      .node_receive_clear_n_o(nrc_n), .node_send_request_n_o(nsr_n), .doze_o(doze),
      .radio_off_o(roff));
   host_model #(.BIT_P(BIT)) host (
      .clock_i(clock_i), .serial_i(stx), .request_n_i(nsr_n), .delay_i(dly),
      .drop_i(drop), .clear_n_o(clr_n), .byte_o(hbyte), .strobe_o(hstb));

   // Clock and cycle count since reset release
   always #12.5 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= reset_i ? 0 : cyc + 1;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // Wait for an observed output to reach a level within a bound
   task wait_lvl(input int k, input logic v, input int lim);
      n = 0;
      while (obs[k] !== v && n <= lim) begin
         @(negedge clock_i);
         n++;
      end
      check(32'(n <= lim), 32'h1);
   endtask : wait_lvl

   task send_byte(input logic [7:0] b, input int len);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      rq.push_back(b);
      for (int i = 0; i < 10; i++) begin
         srx = f[i];
         repeat (len) @(negedge clock_i);
      end
   endtask : send_byte

   task tx_put(input logic [7:0] b, input logic last);
      txb = '{last, b};
      valid = 1'b1;
      tq.push_back(b);
   endtask : tx_put

   task end_sim();
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Compare each delivered byte with the oldest note; host bytes with no note left only go into got_word
   always @(negedge clock_i) begin
      if (rxv === 1'b1) check(rxd, rq.pop_front());
      if (hstb === 1'b1) begin
         got_word = {got_word[23:0], hbyte};
         nstb++;
         if (tq.size() > 0) check(hbyte, tq.pop_front());
      end
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      reset_i = 1'b0;
      check({stx, nrc_n, nsr_n, doze, roff}, 5'h1C);
      // Host packet, second byte two percent fast
      req_n = 1'b0;
      wait_lvl(2, 1'b0, 2);
      repeat (20) @(negedge clock_i);
      send_byte(8'($random(seed)), BIT);
      send_byte(8'($random(seed)), 340);
      req_n = 1'b1;
      wait_lvl(2, 1'b1, 2);
      // Node packet; host drops clear in the first byte, which must finish
      tx_put(8'($random(seed)), 1'b0);
      wait_lvl(6, 1'b0, 100);
      drop <= 1'b1;
      dly  <= 16'h0FA0;
      wait_lvl(5, 1'b0, 2 * BIT);
      wait_lvl(4, 1'b1, 2);
      @(negedge clock_i);
      drop <= 1'b0;
      tx_put(8'($random(seed)), 1'b1);
      wait_lvl(4, 1'b1, 8000);
      valid = 1'b0;
      dly <= 16'h0028;
      wait_lvl(3, 1'b1, 11 * BIT);
      // Time strobe; packet carries microseconds since reset
      repeat (20) @(negedge clock_i);
      ts_n = 1'b0;
      repeat (5000) @(negedge clock_i);
      ts_n = 1'b1;
      tus = 32'(cyc / 40);
      nstb = 0;
      for (n = 0; nstb < 4 && n < 20000; n++) @(negedge clock_i);
      check(32'(n < 20000), 32'h1);
      check(32'((got_word - tus + 32'h2) <= 32'h4), 32'h1);
      // Doze and radio strobes
      doze_n = 1'b0;
      wait_lvl(1, 1'b1, 2);
      doze_n = 1'b1;
      wait_lvl(1, 1'b0, 2);
      radio = 1'b1;
      wait_lvl(0, 1'b1, 2);
      radio = 1'b0;
      wait_lvl(0, 1'b0, 2);
      // Packet-gap mode: clear withheld for the gap after a packet
      gap = 1'b1;
      req_n = 1'b0;
      wait_lvl(2, 1'b0, 2);
      send_byte(8'($random(seed)), BIT);
      req_n = 1'b1;
      wait_lvl(2, 1'b1, 2);
      req_n = 1'b0;
      wait_lvl(2, 1'b0, GAP + 4);
      check(32'(n >= GAP - 4), 32'h1);
      req_n = 1'b1;
      wait_lvl(2, 1'b1, 2);
      // Node request held back for the gap after the receive packet
      tx_put(8'($random(seed)), 1'b1);
      wait_lvl(3, 1'b0, GAP + 4);
      check(32'(n >= GAP - 4), 32'h1);
      wait_lvl(4, 1'b1, 200);
      valid = 1'b0;
      wait_lvl(3, 1'b1, 11 * BIT);
      // Every noted byte must have been delivered
      check(32'(rq.size()), 32'h0);
      check(32'(tq.size()), 32'h0);
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      repeat (80000) @(posedge clock_i);
      err_count++;
      end_sim();
   end
endmodule : node_host_link_tb

// >>> verilog/node_host_link.sv
// Node side of the host serial handshake, time packet and host strobes
//
// Overview of operation
// RL1 - Receive tolerates two percent, transmit within one
// RL2 - Receive clear follows host request within 22 ms
// RL3 - Host starts first byte within 20 ms
// RL4 - Host drops request within 22 ms after packet
// RL5 - Host answers node request within 22 ms
// RL6 - Node starts byte within two bit periods
// RL7 - Node drops request within one bit after packet
// RL8 - Clear may drop anytime; started byte completes
// RL9 - Packet-gap mode leaves 100 ms between packets
// RL10 - Host holds time strobe until packet received
// RL11 - Time packet sent within 100 ms of strobe
// RL12 - Reported time has one microsecond resolution
// RL13 - Doze within 20 ms of doze strobe fall
// RL14 - Radio off within 20 ms of strobe rise
// RL15 - Handshake request and clear lines are active low
module node_host_link #(
   parameter int unsigned GAP_CYCLES_P = node_link_pkg::GAP_CYCLES  // Inter-packet gap
) (
   input  wire logic                     clock_i,                // 40 MHz clock
   input  wire logic                     reset_i,                // Async reset, high
   input  wire node_link_pkg::host_pins_t host_i,                // Host control pins
   input  wire logic                     serial_rx_i,            // Serial data from host
   input  wire logic                     gap_mode_i,             // Packet-gap mode enable
   input  wire node_link_pkg::link_byte_t tx_byte_i,             // Next node byte to send
   input  wire logic                     tx_valid_i,             // tx_byte_i is valid
   output logic                          tx_take_o,              // Pulse: tx_byte_i taken
   output logic [7:0]                    rx_data_o,              // Received byte
   output logic                          rx_valid_o,             // Pulse: rx_data_o new
   output logic                          serial_tx_o,            // Serial data to host
   output logic                          node_receive_clear_n_o, // Node ready to receive
   output logic                          node_send_request_n_o,  // Node has a packet
   output logic                          doze_o,                 // Node in doze state
   output logic                          radio_off_o             // Radio switched off
);
   node_link_pkg::tx_state_t tx_state_q;
   node_link_pkg::rx_state_t rx_state_q;
   logic [21:0] gap_q;
   logic        ts_prev_q;
   logic        doze_prev_q;
   logic        radio_prev_q;
   logic [5:0]  pre_q;
   logic [31:0] us_q;
   logic [31:0] time_word_q;
   logic        time_pend_q;
   logic        sel_time_q;
   logic        last_q;
   logic [1:0]  byte_idx_q;
   logic        tx_busy;
   logic        tx_done;
   logic [15:0] rx_cnt_q;
   logic [3:0]  rx_bits_q;
   logic [7:0]  rx_shift_q;

   // Edge detection and decode
   wire         gap_open   = (gap_q == 22'h000000);
   wire         ts_rise    = !ts_prev_q && host_i.timestamp_request_n;
   wire         doze_fall  = doze_prev_q && !host_i.doze_request_n;
   wire         doze_rise  = !doze_prev_q && host_i.doze_request_n;
   wire         radio_rise = !radio_prev_q && host_i.radio_disable;
   wire         radio_fall = radio_prev_q && !host_i.radio_disable;
   wire         host_clear = !host_i.receive_clear_n;                // RL15
   wire         time_busy  = sel_time_q && (tx_state_q != node_link_pkg::TX_IDLE);
   wire [31:0]  time_shift = time_word_q >> {~byte_idx_q, 3'h0};
   wire [7:0]   cur_data   = sel_time_q ? time_shift[7:0] : tx_byte_i.data;
   wire         cur_last   = sel_time_q ? (byte_idx_q == node_link_pkg::TIME_LAST_BYTE)
                                        : tx_byte_i.last;
   wire         have_byte  = sel_time_q || tx_valid_i;
   wire         tx_start   = (tx_state_q == node_link_pkg::TX_WAIT) && host_clear && have_byte;
   // Last flag is held from the byte's start; the user may already show the next byte
   wire         tx_pkt_end = tx_done && last_q;
   wire         rx_pkt_end = host_i.send_request_n && !node_receive_clear_n_o;
   wire         rx_bit_end = (rx_state_q == node_link_pkg::RX_BITS) && (rx_cnt_q == 16'h0000);
   wire         prescale_end = (pre_q == node_link_pkg::CYCLES_PER_US - 6'h01);

   // Serializer for node bytes
   serial_frame_tx u_frame_tx (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .start_i (tx_start),
      .data_i  (cur_data),
      .line_o  (serial_tx_o),
      .busy_o  (tx_busy),
      .done_o  (tx_done)
   );

   // Strobe trackers and host-requested power states
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ts_prev_q    <= node_link_pkg::TS_IDLE;
         doze_prev_q  <= node_link_pkg::DOZE_IDLE;
         radio_prev_q <= node_link_pkg::RADIO_IDLE;
         doze_o       <= 1'b0;
         radio_off_o  <= 1'b0;
      end else begin
         ts_prev_q    <= host_i.timestamp_request_n;
         doze_prev_q  <= host_i.doze_request_n;
         radio_prev_q <= host_i.radio_disable;
         if (doze_fall) doze_o <= 1'b1;          // RL13
         else if (doze_rise) doze_o <= 1'b0;
         if (radio_rise) radio_off_o <= 1'b1;    // RL14
         else if (radio_fall) radio_off_o <= 1'b0;
      end
   end

   // Microsecond time base and time capture on the strobe's rising edge
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pre_q       <= 6'h00;
         us_q        <= 32'h00000000;
         time_word_q <= 32'h00000000;
         time_pend_q <= 1'b0;
      end else begin
         pre_q <= prescale_end ? 6'h00 : pre_q + 6'h01;
         if (prescale_end) us_q <= us_q + 32'h00000001;               // RL12
         if (sel_time_q && tx_pkt_end) time_pend_q <= 1'b0;
         if (ts_rise && !time_busy) begin                              // RL11
            time_word_q <= us_q;
            time_pend_q <= 1'b1;
         end
      end
   end

   // Inter-packet gap, restarted at the end of a packet either way
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gap_q <= 22'h000000;
      end else if (gap_mode_i && (tx_pkt_end || rx_pkt_end)) begin
         gap_q <= 22'(GAP_CYCLES_P - 1);                              // RL9
      end else if (!gap_open) begin
         gap_q <= gap_q - 22'h000001;
      end
   end

   // Receive clear tracks the host request; asserted only once the gap is over
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         node_receive_clear_n_o <= 1'b1;
      end else if (host_i.send_request_n) begin
         node_receive_clear_n_o <= 1'b1;                               // RL2
      end else if (gap_open) begin
         node_receive_clear_n_o <= 1'b0;                               // RL2
      end
   end

   // Transmit sequencer: request, wait for clear per byte, finish each byte
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         tx_state_q            <= node_link_pkg::TX_IDLE;
         node_send_request_n_o <= 1'b1;
         sel_time_q            <= 1'b0;
         byte_idx_q            <= 2'h0;
         tx_take_o             <= 1'b0;
         last_q                <= 1'b0;
      end else begin
         tx_take_o <= tx_start && !sel_time_q;
         case (tx_state_q)
            node_link_pkg::TX_IDLE: begin
               if (gap_open && (time_pend_q || tx_valid_i)) begin
                  node_send_request_n_o <= 1'b0;                       // RL15
                  sel_time_q            <= time_pend_q;
                  byte_idx_q            <= 2'h0;
                  tx_state_q            <= node_link_pkg::TX_WAIT;
               end
            end
            node_link_pkg::TX_WAIT: begin
               if (tx_start) begin
                  tx_state_q <= node_link_pkg::TX_SHIFT;               // RL6
                  last_q     <= cur_last;                              // RL7
               end
            end
            node_link_pkg::TX_SHIFT: begin
               if (tx_pkt_end) begin
                  node_send_request_n_o <= 1'b1;                       // RL7
                  tx_state_q            <= node_link_pkg::TX_IDLE;
               end else if (tx_done) begin
                  byte_idx_q <= byte_idx_q + 2'h1;
                  tx_state_q <= node_link_pkg::TX_WAIT;                // RL8
               end
            end
            default: begin
               node_send_request_n_o <= 1'b1;
               tx_state_q            <= node_link_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // Receiver: half-bit start check, then mid-bit samples keep two percent margin
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rx_state_q <= node_link_pkg::RX_IDLE;
         rx_cnt_q   <= 16'h0000;
         rx_bits_q  <= 4'h0;
         rx_shift_q <= 8'h00;
         rx_data_o  <= 8'h00;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         case (rx_state_q)
            node_link_pkg::RX_IDLE: begin
               if (!serial_rx_i) begin
                  rx_state_q <= node_link_pkg::RX_BITS;
                  rx_cnt_q   <= node_link_pkg::HALF_BIT_CYCLES;        // RL1
                  rx_bits_q  <= 4'h0;
               end
            end
            node_link_pkg::RX_BITS: begin
               if (!rx_bit_end) begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end else if (rx_bits_q == 4'h0 && serial_rx_i) begin
                  rx_state_q <= node_link_pkg::RX_IDLE;  // Glitch, not a start bit
               end else if (rx_bits_q == node_link_pkg::STOP_BIT_INDEX) begin
                  rx_state_q <= node_link_pkg::RX_IDLE;
                  rx_data_o  <= rx_shift_q;
                  rx_valid_o <= serial_rx_i;             // Framing error drops byte
               end else begin
                  if (rx_bits_q != 4'h0) rx_shift_q <= {serial_rx_i, rx_shift_q[7:1]};
                  rx_bits_q <= rx_bits_q + 4'h1;
                  rx_cnt_q  <= node_link_pkg::BIT_CYCLES - 16'h0001;
               end
            end
            default: rx_state_q <= node_link_pkg::RX_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   chk_clear_follows: assert property (!host_i.send_request_n && gap_open // RL2
      |=> !node_receive_clear_n_o) else $error("receive clear not asserted");
   chk_clear_release: assert property ($rose(host_i.send_request_n) // RL2
      |=> node_receive_clear_n_o) else $error("receive clear not negated");
   chk_tx_start: assert property ($fell(host_i.receive_clear_n) && !tx_busy && tx_state_q == node_link_pkg::TX_WAIT && have_byte // RL6
      |=> ##[0:1] !serial_tx_o) else $error("byte did not start");
   chk_request_drop: assert property (tx_done && last_q && tx_state_q == node_link_pkg::TX_SHIFT // RL7
      |=> node_send_request_n_o && serial_tx_o) else $error("request not negated after packet");
   chk_byte_finish: assert property (tx_busy && !tx_done && host_i.receive_clear_n // RL8
      |=> tx_busy || tx_done) else $error("byte aborted on clear drop");
   chk_gap_hold: assert property ($fell(node_send_request_n_o) |-> $past(gap_open)) // RL9
      else $error("packet requested inside gap");
   chk_time_capture: assert property (ts_rise && !time_busy // RL11
      |=> time_pend_q && time_word_q == $past(us_q)) else $error("time not captured");
   chk_us_tick: assert property (prescale_end |=> us_q == $past(us_q) + 32'h00000001 // RL12
      ##1 !prescale_end [*8]) else $error("microsecond tick wrong");
   chk_doze_enter: assert property (doze_fall |=> doze_o) // RL13
      else $error("doze not entered");
   chk_doze_hold: assert property (doze_o && !host_i.doze_request_n |=> doze_o) // RL13
      else $error("doze left while strobe low");
   chk_radio_hold: assert property (radio_off_o && host_i.radio_disable |=> radio_off_o) // RL14
      else $error("radio back on while strobe high");
   chk_clear_gap: assert property (!gap_open && node_receive_clear_n_o // RL9
      |=> node_receive_clear_n_o) else $error("receive clear inside gap");
   chk_radio_off: assert property (radio_rise |=> radio_off_o) // RL14
      else $error("radio not switched off");
endmodule : node_host_link

// >>> verilog/node_link_pkg.sv
// Shared constants, carriers and state codes for the host serial link
package node_link_pkg;
   // Clock and serial framing
   localparam int unsigned CLOCK_HZ        = 40_000_000;
   localparam int unsigned CLOCK_PERIOD_NS = 25;
   localparam int unsigned BAUD_HZ         = 115_200;
   localparam logic [15:0] BIT_CYCLES      = 16'(CLOCK_HZ / BAUD_HZ);
   localparam logic [15:0] HALF_BIT_CYCLES = 16'(CLOCK_HZ / BAUD_HZ / 2);
   localparam logic [3:0]  FRAME_LAST_BIT  = 4'h9;
   localparam logic [3:0]  STOP_BIT_INDEX  = 4'h9;

   // Timing limits in their own units
   localparam int unsigned GAP_MS          = 100;
   localparam int unsigned GAP_CYCLES      = CLOCK_HZ / 1000 * GAP_MS;
   localparam int unsigned US_NS           = 1000;
   localparam logic [5:0]  CYCLES_PER_US   = 6'(US_NS / CLOCK_PERIOD_NS);

   // Time packet: four bytes, most significant first
   localparam logic [1:0]  TIME_LAST_BYTE  = 2'h3;

   // Idle levels of the host strobes, used as reset values of the edge trackers
   localparam logic        TS_IDLE         = 1'b1;
   localparam logic        DOZE_IDLE       = 1'b1;
   localparam logic        RADIO_IDLE      = 1'b0;

   typedef struct packed {
      logic send_request_n;       // Host wants to send a packet, low active
      logic receive_clear_n;      // Host ready to take node bytes, low active
      logic timestamp_request_n;  // Time strobe, rising edge requests
      logic doze_request_n;       // Doze strobe, falling edge requests
      logic radio_disable;        // Radio strobe, rising edge requests
   } host_pins_t;

   typedef struct packed {
      logic       last;           // Final byte of the packet
      logic [7:0] data;
   } link_byte_t;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_WAIT  = 4'h2,
      TX_SHIFT = 4'h4,
      TX_SPARE = 4'h8
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h1,
      RX_BITS = 2'h2
   } rx_state_t;
endpackage : node_link_pkg

// >>> verilog/serial_frame_tx.sv
// One-byte serializer: start bit, eight data bits LSB first, stop bit
module serial_frame_tx (
   input  wire logic       clock_i,  // 40 MHz clock
   input  wire logic       reset_i,  // Async reset, high
   input  wire logic       start_i,  // Begin a frame when idle
   input  wire logic [7:0] data_i,   // Byte to send
   output logic            line_o,   // Serial line, idle high
   output logic            busy_o,   // Frame in flight
   output logic            done_o    // Pulse at end of stop bit
);
   logic [9:0]  frame_q;
   logic [3:0]  bits_q;
   logic [15:0] cnt_q;
   wire         bit_end = busy_o && (cnt_q == 16'h0000);

   // Bit timer from the integer divisor keeps the rate well inside one percent
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         frame_q <= 10'h3FF;
         bits_q  <= 4'h0;
         cnt_q   <= 16'h0000;
         line_o  <= 1'b1;
         busy_o  <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            frame_q <= {1'b1, data_i, 1'b0};
            line_o  <= 1'b0;
            busy_o  <= 1'b1;
            bits_q  <= node_link_pkg::FRAME_LAST_BIT;
            cnt_q   <= node_link_pkg::BIT_CYCLES - 16'h0001; // RL1
         end else if (bit_end && bits_q == 4'h0) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            line_o <= 1'b1;
         end else if (bit_end) begin
            frame_q <= {1'b1, frame_q[9:1]};
            line_o  <= frame_q[1];
            bits_q  <= bits_q - 4'h1;
            cnt_q   <= node_link_pkg::BIT_CYCLES - 16'h0001;
         end else if (busy_o) begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end
endmodule : serial_frame_tx
